// ==== rtl/mrr_pkg.sv ====
// package of offsets, fields and reset values for the measurement result bank
`default_nettype none
package mrr_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_OC_THRESH = 8'h06; // over-current threshold
  localparam logic [7:0] OFS_CUR_HI = 8'h10; // current result high
  localparam logic [7:0] OFS_CUR_LO = 8'h11; // current result low
  localparam logic [7:0] OFS_VOLT_HI = 8'h12; // voltage result high
  localparam logic [7:0] OFS_VOLT_LO = 8'h13; // voltage result low
  localparam logic [7:0] OFS_AUX_HI = 8'h14; // auxiliary result high
  localparam logic [7:0] OFS_AUX_LO = 8'h15; // auxiliary result low
  // ==========================================================
  // field positions and reset values
  localparam int HI_NIB_MSB = 3; // result bits 11:8 sit in 3:0
  localparam int POS_IRQ = 5; // interrupt seen
  localparam int POS_WARN = 6; // warning seen
  localparam logic [7:0] OC_THRESH_RST = 8'hFF; // threshold reset code
  localparam logic [7:0] OC_THRESH_MIN = 8'h10; // advised lower bound
  localparam logic [11:0] RESULT_RST = 12'h000; // result reset value
  localparam logic [7:0] UNMAPPED_RD = 8'h00; // answer for unused offsets
  // ==========================================================
  // scaling in microvolts per code (documentation only, no logic)
  localparam int OC_UV_PER_CODE = 1000; // threshold step 1 mV
  localparam int RES_UV_X100_PER_CODE = 122000; // 1.22 mV times 100
  // channel indices
  localparam int CH_CUR = 0;
  localparam int CH_VOLT = 1;
  localparam int CH_AUX = 2;
  localparam int NUM_CH = 3;
  // over-current comparator input select
  typedef enum logic [0:0] {
    OC_SRC_MAIN = 1'b0, // main current input pair
    OC_SRC_SEC = 1'b1 // secondary voltage input pair
  } mrr_oc_src_t;
endpackage : mrr_pkg
`default_nettype wire

// ==== rtl/mrr_result_if.sv ====
// interface carrying one channel's capture strobe and code to a holder, and its stored code back
`default_nettype none
interface mrr_result_if;
  logic load; // capture strobe for this channel
  logic [11:0] code; // new two's complement code
  logic [11:0] held; // stored code
  modport holder (input load, input code, output held);
  modport user (output load, output code, input held);
endinterface : mrr_result_if
`default_nettype wire

// ==== rtl/mrr_result_hold.sv ====
// one 12-bit result holder, cleared to zero at reset
`default_nettype none
module mrr_result_hold (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // channel side
  mrr_result_if.holder ch
);
  // ==========================================================
  // capture: result only changes on the converter's strobe or at reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ch.held <= mrr_pkg::RESULT_RST;
    end else if (ch.load) begin
      ch.held <= ch.code;
    end
  end
endmodule : mrr_result_hold
`default_nettype wire

// ==== rtl/mrr_bank.sv ====
// measurement result register bank with over-current threshold
// Notes on behaviour
// - threshold code 8 bits, resets to ones
// - current result split at 10h/11h
// - current code step 1.22 mV scaled
// - voltage result split at 12h/13h
// - voltage code step 1.22 mV over gain
// - auxiliary result high nibble at 14h
// - bit 5 is inverse of interrupt pin
// - bit 6 shows any warning condition
// - results and flags reset zero, read-only
// - config bit picks comparator input pair
`default_nettype none
module mrr_bank (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // converter results, one strobe per channel
  input wire logic [2:0] res_load,
  input wire logic [11:0] cur_code,
  input wire logic [11:0] volt_code,
  input wire logic [11:0] aux_code,
  // status from the rest of the device
  input wire logic interrupt_pin_n,
  input wire logic over_temp,
  input wire logic under_volt,
  input wire logic over_cur,
  input wire logic oc_channel_sel,
  // to the analog over-current comparator
  output logic [7:0] oc_thresh,
  output logic oc_src_sec
);
  // ==========================================================
  // threshold register
  logic [7:0] oc_thresh_r; // programmed code, 1 mV per step
  logic [7:0] oc_thresh_nxt;

  // software writes replace the code; no clamp applied to low codes
  always_comb begin
    oc_thresh_nxt = oc_thresh_r;
    if (reg_wr && reg_addr == mrr_pkg::OFS_OC_THRESH) begin
      oc_thresh_nxt = reg_wdata;
    end
  end

  // reset to all ones so the trip point starts at its highest
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      oc_thresh_r <= mrr_pkg::OC_THRESH_RST;
    end else begin
      oc_thresh_r <= oc_thresh_nxt;
    end
  end

  // threshold drives the comparator DAC directly
  assign oc_thresh = oc_thresh_r;

  // ==========================================================
  // comparator input select
  mrr_pkg::mrr_oc_src_t oc_src;
  // zero picks main current pair, one picks secondary pair
  assign oc_src = mrr_pkg::mrr_oc_src_t'(oc_channel_sel);
  assign oc_src_sec = (oc_src == mrr_pkg::OC_SRC_SEC);

  // ==========================================================
  // result holders; codes already in 1.22 mV steps from the converter
  mrr_result_if ch_if[mrr_pkg::NUM_CH] ();
  logic [11:0] codes [mrr_pkg::NUM_CH]; // incoming codes by channel
  logic [11:0] held [mrr_pkg::NUM_CH]; // stored codes by channel

  assign codes[mrr_pkg::CH_CUR] = cur_code;
  assign codes[mrr_pkg::CH_VOLT] = volt_code;
  assign codes[mrr_pkg::CH_AUX] = aux_code;

  genvar gi;
  generate
    for (gi = 0; gi < mrr_pkg::NUM_CH; gi++) begin : g_ch
      assign ch_if[gi].load = res_load[gi];
      assign ch_if[gi].code = codes[gi];
      assign held[gi] = ch_if[gi].held;
      mrr_result_hold u_hold (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ch(ch_if[gi])
      );
    end
  endgenerate

  // ==========================================================
  // flag registers, reset to zero
  logic irq_seen_r; // inverse of interrupt pin
  logic warn_seen_r; // any warning condition

  // flags registered so reads are glitch free
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_seen_r <= 1'b0;
      warn_seen_r <= 1'b0;
    end else begin
      irq_seen_r <= ~interrupt_pin_n;
      warn_seen_r <= over_temp | under_volt | over_cur;
    end
  end

  // ==========================================================
  // high register assembly: 7 and 4 zero, 6 warn, 5 irq, 3:0 nibble
  function automatic logic [7:0] hi_byte(input logic [11:0] v,
                                         input logic irq,
                                         input logic warn);
    logic [7:0] b;
    b = 8'h00;
    b[mrr_pkg::HI_NIB_MSB:0] = v[11:8];
    b[mrr_pkg::POS_IRQ] = irq;
    b[mrr_pkg::POS_WARN] = warn;
    return b;
  endfunction : hi_byte

  // ==========================================================
  // read mux; writes to result offsets are ignored (read-only)
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;

  always_comb begin
    rdata_nxt = mrr_pkg::UNMAPPED_RD;
    case (reg_addr)
      mrr_pkg::OFS_OC_THRESH: rdata_nxt = oc_thresh_r;
      mrr_pkg::OFS_CUR_HI: begin
        rdata_nxt = hi_byte(held[mrr_pkg::CH_CUR], irq_seen_r,
                            warn_seen_r);
      end
      mrr_pkg::OFS_CUR_LO: rdata_nxt = held[mrr_pkg::CH_CUR][7:0];
      mrr_pkg::OFS_VOLT_HI: begin
        rdata_nxt = hi_byte(held[mrr_pkg::CH_VOLT], irq_seen_r,
                            warn_seen_r);
      end
      mrr_pkg::OFS_VOLT_LO: rdata_nxt = held[mrr_pkg::CH_VOLT][7:0];
      mrr_pkg::OFS_AUX_HI: begin
        rdata_nxt = hi_byte(held[mrr_pkg::CH_AUX], irq_seen_r,
                            warn_seen_r);
      end
      mrr_pkg::OFS_AUX_LO: rdata_nxt = held[mrr_pkg::CH_AUX][7:0];
      default: rdata_nxt = mrr_pkg::UNMAPPED_RD;
    endcase
  end

  // read data captured on a read strobe and held until the next one
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // checks
  threshold_reset_a: assert property (@(posedge sys_clk)
    $rose(rst_b) |-> oc_thresh == mrr_pkg::OC_THRESH_RST)
    else $error("threshold not all ones after reset");

  threshold_write_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_wr && reg_addr == mrr_pkg::OFS_OC_THRESH |=> oc_thresh ==
      $past(reg_wdata))
    else $error("threshold write not taken");

  irq_flag_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == mrr_pkg::OFS_CUR_HI && !$past(rst_b) == 1'b0
      |=> reg_rdata[mrr_pkg::POS_IRQ] == ~$past(interrupt_pin_n, 2))
    else $error("interrupt flag not inverse of pin");

  warn_flag_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == mrr_pkg::OFS_VOLT_HI && $past(rst_b)
      |=> reg_rdata[mrr_pkg::POS_WARN] == $past(over_temp | under_volt
        | over_cur, 2))
    else $error("warning flag wrong");

  spare_bits_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_rd && (reg_addr == mrr_pkg::OFS_CUR_HI ||
      reg_addr == mrr_pkg::OFS_AUX_HI) |=> reg_rdata[7] == 1'b0 &&
      reg_rdata[4] == 1'b0)
    else $error("spare bits not zero");

  cur_low_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == mrr_pkg::OFS_CUR_LO |=>
      reg_rdata == $past(held[mrr_pkg::CH_CUR][7:0]))
    else $error("current low byte wrong");

  volt_high_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == mrr_pkg::OFS_VOLT_HI |=>
      reg_rdata[3:0] == $past(held[mrr_pkg::CH_VOLT][11:8]))
    else $error("voltage high nibble wrong");

  result_reset_a: assert property (@(posedge sys_clk)
    !rst_b |=> held[mrr_pkg::CH_AUX] == 12'h000 && !irq_seen_r &&
      !warn_seen_r)
    else $error("results not cleared by reset");

  src_select_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    oc_src_sec == oc_channel_sel)
    else $error("comparator source select wrong");

  // ==========================================================
  // read request sequences; the data for each shows one edge later
  sequence thresh_rd_s;
    reg_rd && reg_addr == mrr_pkg::OFS_OC_THRESH;
  endsequence

  sequence cur_hi_rd_s;
    reg_rd && reg_addr == mrr_pkg::OFS_CUR_HI;
  endsequence

  sequence volt_lo_rd_s;
    reg_rd && reg_addr == mrr_pkg::OFS_VOLT_LO;
  endsequence

  sequence aux_hi_rd_s;
    reg_rd && reg_addr == mrr_pkg::OFS_AUX_HI;
  endsequence

  // flags lag their pins one edge; need one edge out of reset first
  sequence settled_s;
    $past(rst_b);
  endsequence

  // ==========================================================
  // read path, capture and reset checks
  thresh_read_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    thresh_rd_s |=> reg_rdata == $past(oc_thresh))
    else $error("threshold read back wrong");

  thresh_keep_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !(reg_wr && reg_addr == mrr_pkg::OFS_OC_THRESH) |=> $stable(oc_thresh))
    else $error("threshold moved without a write");

  cur_high_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    cur_hi_rd_s |=> reg_rdata[3:0] == $past(held[mrr_pkg::CH_CUR][11:8]))
    else $error("current high nibble wrong");

  cur_flags_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    cur_hi_rd_s ##0 settled_s |=>
      reg_rdata[mrr_pkg::POS_IRQ] == ~$past(interrupt_pin_n, 2) &&
      reg_rdata[mrr_pkg::POS_WARN] == $past(over_temp | under_volt |
        over_cur, 2))
    else $error("current high flags wrong");

  volt_low_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    volt_lo_rd_s |=> reg_rdata == $past(held[mrr_pkg::CH_VOLT][7:0]))
    else $error("voltage low byte wrong");

  volt_spare_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == mrr_pkg::OFS_VOLT_HI |=> reg_rdata[7] == 1'b0 &&
      reg_rdata[4] == 1'b0)
    else $error("voltage spare bits not zero");

  aux_high_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    aux_hi_rd_s |=> reg_rdata[3:0] == $past(held[mrr_pkg::CH_AUX][11:8]))
    else $error("auxiliary high nibble wrong");

  aux_flags_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    aux_hi_rd_s ##0 settled_s |=>
      reg_rdata[mrr_pkg::POS_IRQ] == ~$past(interrupt_pin_n, 2) &&
      reg_rdata[mrr_pkg::POS_WARN] == $past(over_temp | under_volt |
        over_cur, 2))
    else $error("auxiliary high flags wrong");

  cur_load_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    res_load[mrr_pkg::CH_CUR] |=> held[mrr_pkg::CH_CUR] == $past(cur_code))
    else $error("current code not captured");

  volt_load_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    res_load[mrr_pkg::CH_VOLT] |=>
      held[mrr_pkg::CH_VOLT] == $past(volt_code))
    else $error("voltage code not captured");

  aux_load_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    res_load[mrr_pkg::CH_AUX] |=>
      held[mrr_pkg::CH_AUX] == $past(aux_code))
    else $error("auxiliary code not captured");

  cur_keep_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !res_load[mrr_pkg::CH_CUR] |=> $stable(held[mrr_pkg::CH_CUR]))
    else $error("current result moved without a strobe");

  volt_keep_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !res_load[mrr_pkg::CH_VOLT] |=> $stable(held[mrr_pkg::CH_VOLT]))
    else $error("voltage result moved without a strobe");

  aux_keep_a: assert property (@(posedge sys_clk)
    disable iff (!rst_b)
    !res_load[mrr_pkg::CH_AUX] |=> $stable(held[mrr_pkg::CH_AUX]))
    else $error("auxiliary result moved without a strobe");

  results_clear_a: assert property (@(posedge sys_clk)
    !rst_b |=> held[mrr_pkg::CH_CUR] == mrr_pkg::RESULT_RST &&
      held[mrr_pkg::CH_VOLT] == mrr_pkg::RESULT_RST)
    else $error("current or voltage result not cleared");

  rdata_clear_a: assert property (@(posedge sys_clk)
    !rst_b |=> reg_rdata == 8'h00)
    else $error("read data not cleared by reset");
endmodule : mrr_bank
`default_nettype wire

// ==== tb/mrr_host_model.sv ====
// host model that issues register writes and reads to the bank
`default_nettype none
module mrr_host_model (
  // clock
  input wire logic sys_clk,
  // register port toward the bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write; address and data are scrambled after the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // one-cycle read; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask : rd
endmodule : mrr_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the measurement result bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [2:0] res_load = 3'h0;
  logic [11:0] cur_code = 12'h000;
  logic [11:0] volt_code = 12'h000;
  logic [11:0] aux_code = 12'h000;
  logic interrupt_pin_n = 1'b1; // pin idles high, no interrupt
  logic over_temp = 1'b0;
  logic under_volt = 1'b0;
  logic over_cur = 1'b0;
  logic oc_channel_sel = 1'b0;
  logic [7:0] oc_thresh;
  logic oc_src_sec;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0; // cycle count for the hang guard
  always #5 sys_clk = ~sys_clk;
  mrr_bank dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .res_load(res_load), .cur_code(cur_code),
    .volt_code(volt_code), .aux_code(aux_code),
    .interrupt_pin_n(interrupt_pin_n), .over_temp(over_temp),
    .under_volt(under_volt), .over_cur(over_cur),
    .oc_channel_sel(oc_channel_sel), .oc_thresh(oc_thresh),
    .oc_src_sec(oc_src_sec));
  mrr_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ==========================================================
  // helpers
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk8($sformatf("reg %h", a), e, v);
  endtask : rd_chk
  // expected high register: bits 4 and 7 stay zero
  function automatic logic [7:0] hi(logic [11:0] c, logic i, logic w);
    return {1'b0, w, i, 1'b0, c[11:8]};
  endfunction : hi
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk8("oc_thresh", 8'hFF, oc_thresh);
    rd_chk(8'h06, 8'hFF);
    for (int a = 8'h10; a <= 8'h15; a++) rd_chk(8'(a), 8'h00);
    rd_chk(8'h30, 8'h00); // unmapped offset reads zero
    $display("t_reset done");
  endtask : t_reset
  task automatic t_thresh();
    host.wr(8'h06, 8'h20); // kept above the advised floor
    chk8("oc_thresh", 8'h20, oc_thresh);
    host.wr(8'h10, 8'hFF);
    host.wr(8'h11, 8'h5A);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h06, 8'h20);
    $display("t_thresh done");
  endtask : t_thresh
  task automatic t_results();
    cur_code = 12'hA5C; // negative code
    volt_code = 12'h7FF; // most positive code
    aux_code = 12'h801; // near most negative code
    res_load = 3'h7;
    @(posedge sys_clk);
    #1;
    res_load = 3'h0;
    rd_chk(8'h10, hi(12'hA5C, 1'b0, 1'b0));
    rd_chk(8'h11, 8'h5C);
    rd_chk(8'h12, hi(12'h7FF, 1'b0, 1'b0));
    rd_chk(8'h13, 8'hFF);
    rd_chk(8'h14, hi(12'h801, 1'b0, 1'b0));
    rd_chk(8'h15, 8'h01);
    $display("t_results done");
  endtask : t_results
  task automatic t_flags();
    interrupt_pin_n = 1'b0;
    rd_chk(8'h10, hi(12'hA5C, 1'b1, 1'b0));
    rd_chk(8'h14, hi(12'h801, 1'b1, 1'b0));
    interrupt_pin_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {over_temp, under_volt, over_cur} = 3'h1 << i;
      rd_chk(8'h12, hi(12'h7FF, 1'b0, 1'b1));
      {over_temp, under_volt, over_cur} = 3'h0;
      rd_chk(8'h12, hi(12'h7FF, 1'b0, 1'b0));
    end
    $display("t_flags done");
  endtask : t_flags
  task automatic t_select();
    for (int i = 0; i < 2; i++) begin
      oc_channel_sel = i[0];
      #1;
      chk8("oc_src_sec", {7'h00, i[0]}, {7'h00, oc_src_sec});
    end
    $display("t_select done");
  endtask : t_select
  // one channel strobed alone, then a reset in mid-run restores defaults
  task automatic t_rereset();
    cur_code = 12'h3C7;
    volt_code = 12'h123; // a stray voltage strobe would show 23h
    res_load = 3'h1;
    @(posedge sys_clk);
    #1;
    res_load = 3'h0;
    rd_chk(8'h11, 8'hC7);
    rd_chk(8'h13, 8'hFF);
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk8("reg_rdata", 8'h00, reg_rdata);
    chk8("oc_thresh", 8'hFF, oc_thresh);
    rd_chk(8'h06, 8'hFF);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h14, 8'h00);
    $display("t_rereset done");
  endtask : t_rereset
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_thresh();
    t_results();
    t_flags();
    t_select();
    t_rereset();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
